// *** gofr_pkg.sv ***
// shared constants and types of the rate sensor output and filter block
`default_nettype none
package gofr_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned SAMPLE_SPS  = 2429;
  localparam int unsigned SAMPLE_CYC  = CLK_HZ / SAMPLE_SPS;   // sample period, rounded down
  localparam int unsigned FLASH_MS    = 40;
  localparam int unsigned FLASH_CYC   = (CLK_HZ / 1000) * FLASH_MS;
  // byte addresses of the register map
  localparam logic [5:0] ADDR_SUPPLY  = 6'h02;
  localparam logic [5:0] ADDR_RATE    = 6'h04;
  localparam logic [5:0] ADDR_EXT     = 6'h06;
  localparam logic [5:0] ADDR_AUX     = 6'h0a;
  localparam logic [5:0] ADDR_TEMP    = 6'h0c;
  localparam logic [5:0] ADDR_DECIM   = 6'h36;
  localparam logic [5:0] ADDR_RANGE   = 6'h38;
  localparam logic [5:0] ADDR_FAULT   = 6'h3c;
  localparam logic [5:0] ADDR_CMD     = 6'h3e;
  // values after reset and writable bits
  localparam logic [15:0] DECIM_RST   = 16'h0000;
  localparam logic [15:0] RANGE_RST   = 16'h0401;
  localparam logic [15:0] DECIM_MASK  = 16'h000f;
  localparam logic [15:0] RANGE_MASK  = 16'h0707;
  // field positions
  localparam int unsigned NEW_BIT     = 15;
  localparam int unsigned ERR_BIT     = 14;
  localparam int unsigned WR_BIT      = 15;
  localparam int unsigned WR_ZERO_BIT = 14;
  localparam int unsigned CMD_FLASH   = 3;
  localparam int unsigned RANGE_LSB   = 8;
  localparam logic [4:0]  FRAME_LAST  = 5'h0f;             // index of last bit in a frame
  // range codes and least tap exponent for each
  localparam logic [2:0] RANGE_14K    = 3'h4;
  localparam logic [2:0] RANGE_7K     = 3'h2;
  localparam logic [2:0] RANGE_3K5    = 3'h1;
  localparam logic [2:0] TAPS_MIN     = 3'h1;
  localparam logic [2:0] TAPS_MIN_7K  = 3'h2;
  localparam logic [2:0] TAPS_MIN_3K5 = 3'h4;
  localparam int unsigned TAP_DEPTH   = 128;               // 2^7 entries per averager
  // index of each new-data flag
  localparam int unsigned NF_SUPPLY   = 0;
  localparam int unsigned NF_RATE     = 1;
  localparam int unsigned NF_AUX      = 2;
  localparam int unsigned NF_TEMP     = 3;
  // control sequencer states
  typedef enum logic [2:0] {
    ST_RESTORE = 3'h1,
    ST_RUN     = 3'h2,
    ST_FLASH   = 3'h4
  } gofr_state_t;
endpackage
`default_nettype wire

// *** gofr_boxcar.sv ***
// one moving-average stage with a run-time length of 2^len samples
`timescale 1ns/1ps
`default_nettype none
module gofr_boxcar (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        in_valid_i,
  input  wire logic [13:0] in_data_i,
  input  wire logic [2:0]  len_log2_i,
  output logic             out_valid_o,
  output logic [13:0]      out_data_o
);
  // whole state of the stage
  typedef struct packed {
    logic [gofr_pkg::TAP_DEPTH-1:0][13:0] hist;  // last samples, ring order
    logic [6:0]  wp;                              // next write slot
    logic [20:0] sum;                             // running sum of the window
    logic [2:0]  len;                             // length the history belongs to
    logic        out_valid;
    logic [13:0] out_data;
  } gofr_box_t;

  gofr_box_t r_reg;
  gofr_box_t r_next;
  logic [13:0] oldest;                            // sample leaving the window
  logic [20:0] sum_new;
  logic [20:0] avg;

  // window update; a change of length restarts from an empty history,
  // which costs a short ramp but avoids a 128-entry re-summation
  always_comb begin
    r_next = r_reg;
    oldest = r_reg.hist[7'(r_reg.wp - (7'h01 << r_reg.len))];
    sum_new = 21'(r_reg.sum + 21'($signed(in_data_i)) - 21'($signed(oldest)));
    avg = 21'($signed(sum_new) >>> r_reg.len);
    r_next.out_valid = 1'b0;
    if (len_log2_i != r_reg.len) begin
      r_next.hist = '0;
      r_next.sum  = 21'h000000;
      r_next.wp   = 7'h00;
      r_next.len  = len_log2_i;
    end else if (in_valid_i) begin
      r_next.hist[r_reg.wp] = in_data_i;
      r_next.wp        = 7'(r_reg.wp + 7'h01);
      r_next.sum       = sum_new;
      r_next.out_data  = avg[13:0];
      r_next.out_valid = 1'b1;
    end
  end

  // state register
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      r_reg     <= '0;
      r_reg.len <= gofr_pkg::TAPS_MIN;
    end else begin
      r_reg <= r_next;
    end
  end

  assign out_valid_o = r_reg.out_valid;
  assign out_data_o  = r_reg.out_data;
endmodule
`default_nettype wire

// *** gofr_regs.sv ***
// rate sensor output words, filter chain, settings and serial register port
`timescale 1ns/1ps
`default_nettype none
module gofr_regs #(
  parameter int unsigned SAMPLE_CYC = gofr_pkg::SAMPLE_CYC,  // cycles per raw sample
  parameter int unsigned FLASH_CYC  = gofr_pkg::FLASH_CYC    // cycles of a flash backup
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        spi_sclk_i,     // serial clock, idles high
  input  wire logic        spi_cs_n_i,     // chip select, active low
  input  wire logic        spi_mosi_i,     // serial data in
  output logic             spi_miso_o,     // serial data out
  output logic             spi_miso_oe_o,  // high while data out is driven
  input  wire logic [13:0] rate_raw_i,     // converted rate sample
  input  wire logic [11:0] temp_raw_i,     // converted temperature sample
  input  wire logic [11:0] supply_raw_i,   // converted supply sample
  input  wire logic [11:0] aux_raw_i,      // converted auxiliary pin sample
  input  wire logic [15:0] fault_flags_i,  // diagnostic fault flags
  input  wire logic [15:0] nvm_decim_i,    // stored decimation setting
  input  wire logic [15:0] nvm_range_i,    // stored range and filter setting
  output logic             nvm_prog_o,     // high during a backup
  output logic [15:0]      nvm_decim_o,    // decimation setting to store
  output logic [15:0]      nvm_range_o     // range and filter setting to store
);
  // whole state of the block
  typedef struct packed {
    logic        sclk_s1;          // synchroniser stages
    logic        sclk_s2;
    logic        sclk_s3;          // previous sclk level, for edges
    logic        cs_s1;
    logic        cs_s2;
    logic        mosi_s1;
    logic        mosi_s2;
    logic [15:0] rx;               // incoming frame
    logic [4:0]  bitcnt;           // bits taken in this frame
    logic [15:0] tx;               // outgoing frame
    logic        tx_armed;         // last frame was a read request
    logic        miso;
    logic        miso_oe;
    logic [15:0] decim_ctl;        // decimation_control
    logic [15:0] range_ctl;        // range_filter_control
    gofr_pkg::gofr_state_t state;
    logic [21:0] flash_cnt;        // backup duration counter
    logic        nvm_prog;
    logic [15:0] nvm_decim;
    logic [15:0] nvm_range;
    logic [14:0] smp_cnt;          // raw sample period counter
    logic        smp_tick;         // one raw sample this cycle
    logic [28:0] acc;              // decimator sum
    logic [14:0] dec_cnt;          // samples in the decimator sum
    logic [11:0] supply;
    logic [13:0] rate;
    logic [15:0] ext;
    logic [11:0] aux;
    logic [11:0] temp;
    logic [3:0]  newf;             // new-data flags
  } gofr_regs_t;

  gofr_regs_t r_reg;
  gofr_regs_t r_next;

  // filter chain wiring
  logic        f1_valid;
  logic [13:0] f1_data;
  logic        f2_valid;
  logic [13:0] f2_data;
  logic [2:0]  taps_eff;           // tap exponent after range limit

  // decode helpers, set at the top of the process
  logic        rise;
  logic        fall;
  logic [15:0] frame;              // complete frame on its last bit
  logic [5:0]  fr_addr;
  logic [7:0]  fr_data;
  logic        err_flag;
  logic [3:0]  nf_clr;
  logic [3:0]  nf_set;
  logic [15:0] rd_word;
  logic [28:0] dec_sum;
  logic [28:0] dec_shift;
  logic [15:0] dec_low;
  logic [14:0] dec_last;

  // effective tap exponent: range minimum overrides a smaller field,
  // the stored field keeps its value, so range and field may be written in either order
  always_comb begin
    taps_eff = r_reg.range_ctl[2:0];
    if (taps_eff < gofr_pkg::TAPS_MIN) begin
      taps_eff = gofr_pkg::TAPS_MIN;
    end
    if (r_reg.range_ctl[10:8] == gofr_pkg::RANGE_3K5 &&
        taps_eff < gofr_pkg::TAPS_MIN_3K5) begin
      taps_eff = gofr_pkg::TAPS_MIN_3K5;
    end else if (r_reg.range_ctl[10:8] == gofr_pkg::RANGE_7K &&
                 taps_eff < gofr_pkg::TAPS_MIN_7K) begin
      taps_eff = gofr_pkg::TAPS_MIN_7K;
    end
  end

  // two cascaded averagers give the triangular response
  gofr_boxcar u_stage1 (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (r_reg.smp_tick),
    .in_data_i   (rate_raw_i),
    .len_log2_i  (taps_eff),
    .out_valid_o (f1_valid),
    .out_data_o  (f1_data)
  );

  gofr_boxcar u_stage2 (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (f1_valid),
    .in_data_i   (f1_data),
    .len_log2_i  (taps_eff),
    .out_valid_o (f2_valid),
    .out_data_o  (f2_data)
  );

  // next-state logic
  always_comb begin
    r_next    = r_reg;
    rise      = r_reg.sclk_s2 & ~r_reg.sclk_s3;
    fall      = ~r_reg.sclk_s2 & r_reg.sclk_s3;
    frame     = {r_reg.rx[14:0], r_reg.mosi_s2};
    fr_addr   = frame[13:8];
    fr_data   = frame[7:0];
    err_flag  = |fault_flags_i;
    nf_clr    = 4'h0;
    nf_set    = 4'h0;
    rd_word   = 16'h0000;
    dec_sum   = 29'(r_reg.acc + 29'($signed(f2_data)));
    dec_shift = 29'($signed(dec_sum) >>> r_reg.decim_ctl[3:0]);
    dec_low   = dec_sum[15:0] << (5'h10 - {1'b0, r_reg.decim_ctl[3:0]});
    dec_last  = 15'((16'h0001 << r_reg.decim_ctl[3:0]) - 16'h0001);

    // synchronisers; the second stages and sclk_s3 feed logic
    r_next.sclk_s1 = spi_sclk_i;
    r_next.sclk_s2 = r_reg.sclk_s1;
    r_next.sclk_s3 = r_reg.sclk_s2;
    r_next.cs_s1   = spi_cs_n_i;
    r_next.cs_s2   = r_reg.cs_s1;
    r_next.mosi_s1 = spi_mosi_i;
    r_next.mosi_s2 = r_reg.mosi_s1;

    // read answer: word addressed by the frame, even and odd alike
    if ({fr_addr[5:1], 1'b0} == gofr_pkg::ADDR_SUPPLY) begin
      rd_word = {r_reg.newf[gofr_pkg::NF_SUPPLY], err_flag, 2'h0, r_reg.supply};
    end else if ({fr_addr[5:1], 1'b0} == gofr_pkg::ADDR_RATE) begin
      rd_word = {r_reg.newf[gofr_pkg::NF_RATE], err_flag, r_reg.rate};
    end else if ({fr_addr[5:1], 1'b0} == gofr_pkg::ADDR_EXT) begin
      rd_word = r_reg.ext;
    end else if ({fr_addr[5:1], 1'b0} == gofr_pkg::ADDR_AUX) begin
      rd_word = {r_reg.newf[gofr_pkg::NF_AUX], err_flag, 2'h0, r_reg.aux};
    end else if ({fr_addr[5:1], 1'b0} == gofr_pkg::ADDR_TEMP) begin
      rd_word = {r_reg.newf[gofr_pkg::NF_TEMP], err_flag, 2'h0, r_reg.temp};
    end else if ({fr_addr[5:1], 1'b0} == gofr_pkg::ADDR_DECIM) begin
      rd_word = r_reg.decim_ctl;
    end else if ({fr_addr[5:1], 1'b0} == gofr_pkg::ADDR_RANGE) begin
      rd_word = r_reg.range_ctl;
    end else if ({fr_addr[5:1], 1'b0} == gofr_pkg::ADDR_FAULT) begin
      rd_word = fault_flags_i;
    end

    // serial slave; deselect aborts a partial frame
    if (r_reg.cs_s2) begin
      r_next.bitcnt  = 5'h00;
      r_next.miso_oe = 1'b0;
    end else begin
      r_next.miso_oe = r_reg.tx_armed;
      if (fall) begin                                      // mode 3: change on falling
        r_next.miso = r_reg.tx[15];
        r_next.tx   = {r_reg.tx[14:0], 1'b0};
      end
      if (rise) begin                                      // mode 3: sample on rising
        r_next.rx     = frame;
        r_next.bitcnt = 5'(r_reg.bitcnt + 5'h01);
        if (r_reg.bitcnt == gofr_pkg::FRAME_LAST) begin
          r_next.bitcnt   = 5'h00;
          r_next.tx_armed = 1'b0;
          if (!frame[gofr_pkg::WR_BIT]) begin
            // read request: answer goes out in the next frame
            r_next.tx       = rd_word;
            r_next.tx_armed = 1'b1;
            if ({fr_addr[5:1], 1'b0} == gofr_pkg::ADDR_SUPPLY) begin
              nf_clr[gofr_pkg::NF_SUPPLY] = 1'b1;
            end else if ({fr_addr[5:1], 1'b0} == gofr_pkg::ADDR_RATE) begin
              nf_clr[gofr_pkg::NF_RATE] = 1'b1;
            end else if ({fr_addr[5:1], 1'b0} == gofr_pkg::ADDR_AUX) begin
              nf_clr[gofr_pkg::NF_AUX] = 1'b1;
            end else if ({fr_addr[5:1], 1'b0} == gofr_pkg::ADDR_TEMP) begin
              nf_clr[gofr_pkg::NF_TEMP] = 1'b1;
            end
          end else if (!frame[gofr_pkg::WR_ZERO_BIT] &&
                       r_reg.state != gofr_pkg::ST_RESTORE) begin
            // byte write; a malformed frame is dropped
            if (fr_addr == gofr_pkg::ADDR_DECIM) begin
              r_next.decim_ctl[7:0] = fr_data & gofr_pkg::DECIM_MASK[7:0];
            end else if (fr_addr == 6'(gofr_pkg::ADDR_DECIM + 6'h01)) begin
              r_next.decim_ctl[15:8] = fr_data & gofr_pkg::DECIM_MASK[15:8];
            end else if (fr_addr == gofr_pkg::ADDR_RANGE) begin
              r_next.range_ctl[7:0] = fr_data & gofr_pkg::RANGE_MASK[7:0];
            end else if (fr_addr == 6'(gofr_pkg::ADDR_RANGE + 6'h01)) begin
              r_next.range_ctl[15:8] = fr_data & gofr_pkg::RANGE_MASK[15:8];
            end else if (fr_addr == gofr_pkg::ADDR_CMD &&
                         fr_data[gofr_pkg::CMD_FLASH] &&
                         r_reg.state == gofr_pkg::ST_RUN) begin
              // snapshot the volatile settings into the backup port
              r_next.nvm_decim = r_reg.decim_ctl;
              r_next.nvm_range = r_reg.range_ctl;
              r_next.nvm_prog  = 1'b1;
              r_next.flash_cnt = 22'h000000;
              r_next.state     = gofr_pkg::ST_FLASH;
            end
          end
        end
      end
    end

    // settings sequencer
    case (r_reg.state)
      gofr_pkg::ST_RESTORE: begin
        // stored copy replaces defaults before any sample is produced
        r_next.decim_ctl = nvm_decim_i & gofr_pkg::DECIM_MASK;
        r_next.range_ctl = nvm_range_i & gofr_pkg::RANGE_MASK;
        r_next.state     = gofr_pkg::ST_RUN;
      end
      gofr_pkg::ST_FLASH: begin
        // backup held for its full time; sampling keeps running
        r_next.flash_cnt = 22'(r_reg.flash_cnt + 22'h000001);
        if (r_reg.flash_cnt == 22'(FLASH_CYC - 1)) begin
          r_next.nvm_prog = 1'b0;
          r_next.state    = gofr_pkg::ST_RUN;
        end
      end
      default: begin
      end
    endcase

    // raw sample timebase, idle while settings load
    r_next.smp_tick = 1'b0;
    if (r_reg.state != gofr_pkg::ST_RESTORE) begin
      r_next.smp_cnt = 15'(r_reg.smp_cnt + 15'h0001);
      if (r_reg.smp_cnt == 15'(SAMPLE_CYC - 1)) begin
        r_next.smp_cnt  = 15'h0000;
        r_next.smp_tick = 1'b1;
      end
    end

    // decimating averager; >= guards a setting lowered mid-sum
    if (f2_valid) begin
      r_next.acc     = dec_sum;
      r_next.dec_cnt = 15'(r_reg.dec_cnt + 15'h0001);
      if (r_reg.dec_cnt >= dec_last) begin
        r_next.acc     = 29'h00000000;
        r_next.dec_cnt = 15'h0000;
        r_next.rate    = dec_shift[13:0];
        r_next.ext     = dec_low;
        r_next.supply  = supply_raw_i;
        r_next.aux     = aux_raw_i;
        r_next.temp    = temp_raw_i;
        nf_set         = 4'hf;
      end
    end

    // a fresh sample wins over a read in the same cycle
    r_next.newf = (r_reg.newf & ~nf_clr) | nf_set;
  end

  // state register
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      r_reg           <= '0;
      r_reg.sclk_s1   <= 1'b1;
      r_reg.sclk_s2   <= 1'b1;
      r_reg.sclk_s3   <= 1'b1;
      r_reg.cs_s1     <= 1'b1;
      r_reg.cs_s2     <= 1'b1;
      r_reg.miso      <= 1'b1;
      r_reg.decim_ctl <= gofr_pkg::DECIM_RST;
      r_reg.range_ctl <= gofr_pkg::RANGE_RST;
      r_reg.state     <= gofr_pkg::ST_RESTORE;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from the state register
  assign spi_miso_o    = r_reg.miso;
  assign spi_miso_oe_o = r_reg.miso_oe;
  assign nvm_prog_o    = r_reg.nvm_prog;
  assign nvm_decim_o   = r_reg.nvm_decim;
  assign nvm_range_o   = r_reg.nvm_range;
endmodule
`default_nettype wire

// *** gofr_regs_assertions.sv ***
// concurrent checks on the ports of the output and filter block
`timescale 1ns/1ps
`default_nettype none
module gofr_regs_assertions #(
  parameter int unsigned FLASH_CYC = 50  // cycles of one backup
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        spi_sclk_i,
  input  wire logic        spi_cs_n_i,
  input  wire logic        spi_miso_o,
  input  wire logic        spi_miso_oe_o,
  input  wire logic        nvm_prog_o,
  input  wire logic [15:0] nvm_decim_o,
  input  wire logic [15:0] nvm_range_o
);
  typedef struct packed {
    logic [31:0] prog_cnt;  // backup cycles seen so far
  } gofr_chk_t;
  gofr_chk_t s_reg;
  gofr_chk_t s_next;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // count backup cycles; cleared while idle so each backup is timed alone
  always_comb begin
    s_next = s_reg;
    s_next.prog_cnt = nvm_prog_o ? s_reg.prog_cnt + 32'h1 : 32'h0;
  end
  // register the helper state
  always_ff @(posedge sys_clk_i) begin
    s_reg <= rst_n_i ? s_next : '0;
  end
  // deselected long enough for the synchroniser to see it
  sequence s_cs_idle;
    spi_cs_n_i [*5];
  endsequence
  // backup running with snapshot already taken
  sequence s_backup_on;
    nvm_prog_o [*3];
  endsequence
  a_miso_off_idle: assert property (s_cs_idle |-> !spi_miso_oe_o)
    else $error("data out driven while deselected");
  a_oe_release: assert property ($rose(spi_cs_n_i) |-> ##[1:5] !spi_miso_oe_o)
    else $error("data out not released after deselect");
  a_miso_on_fall: assert property (
    spi_miso_oe_o && $past(spi_miso_oe_o) && $changed(spi_miso_o)
      |-> !$past(spi_sclk_i, 2) || !$past(spi_sclk_i, 3) || !$past(spi_sclk_i, 4))
    else $error("data out moved outside low clock phase");
  a_flash_length: assert property ($fell(nvm_prog_o) |-> s_reg.prog_cnt == FLASH_CYC)
    else $error("backup length wrong");
  a_prog_bounded: assert property (nvm_prog_o |-> s_reg.prog_cnt < FLASH_CYC)
    else $error("backup overran");
  a_snap_stable: assert property (s_backup_on |-> $stable(nvm_decim_o) && $stable(nvm_range_o))
    else $error("snapshot changed during backup");
  a_snap_masked: assert property (s_backup_on |->
    ((nvm_decim_o & 16'hfff0) == 16'h0000) && ((nvm_range_o & 16'hf8f8) == 16'h0000))
    else $error("unused setting bits stored");
  a_flash_on_frame: assert property ($rose(nvm_prog_o) |-> $past(spi_sclk_i, 2))
    else $error("backup started outside a frame end");
endmodule
`default_nettype wire

// *** gofr_spi_host.sv ***
// serial host model: mode 3 frames of 16 bits, msb first
`timescale 1ns/1ps
`default_nettype none
module gofr_spi_host (
  input  wire logic sys_clk_i,
  input  wire logic miso_i,     // device data out
  input  wire logic miso_oe_i,  // device drive enable
  output var  logic sclk_o,     // idles high between frames
  output var  logic cs_n_o,     // select, active low
  output var  logic mosi_o      // host data out
);
  wire logic line_w;  // data-out wire as the host sees it
  // no pull on the line: a released line shows the inverse of the last bit,
  // so a missing drive enable cannot pass for valid data
  assign line_w = miso_oe_i ? miso_i : ~miso_i;
  // idle levels at time zero
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // one full duplex frame; change on falling clock, capture on rise
  task automatic xfer(input logic [15:0] din, output logic [15:0] dout);
    @(posedge sys_clk_i);
    cs_n_o <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    for (int i = 15; i >= 0; i--) begin
      sclk_o <= 1'b0;
      mosi_o <= din[i];
      repeat (4) @(posedge sys_clk_i);
      dout[i] = line_w;
      sclk_o <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
    end
    cs_n_o <= 1'b1;
    mosi_o <= ~mosi_o;  // a released line must not keep its last bit
    repeat (8) @(posedge sys_clk_i);
  endtask
endmodule
`default_nettype wire

// *** gofr_regs_test.sv ***
// self-checking bench of the output and filter block
`timescale 1ns/1ps
`default_nettype none
module gofr_regs_test;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [13:0] rate = 14'h3ffe;    // steady -2 counts
  logic [11:0] temp = 12'he3f;
  logic [11:0] supply = 12'haaa;
  logic [11:0] aux = 12'h7ae;
  logic [15:0] fault = 16'h0100;   // one fault raised
  logic [15:0] d;                  // last word returned
  wire logic   sclk, cs_n, mosi, miso, miso_oe, prog;
  wire logic [15:0] snap_d, snap_r;
  int          fails = 0;
  int          compares = 0;
  always #10 sys_clk = ~sys_clk;
  // short sample and backup counts keep the run brief
  gofr_regs #(.SAMPLE_CYC(20), .FLASH_CYC(50)) uut (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
    .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe),
    .rate_raw_i(rate), .temp_raw_i(temp), .supply_raw_i(supply), .aux_raw_i(aux),
    .fault_flags_i(fault), .nvm_decim_i(16'hfff3), .nvm_range_i(16'hf9fa),
    .nvm_prog_o(prog), .nvm_decim_o(snap_d), .nvm_range_o(snap_r));
  gofr_spi_host host (
    .sys_clk_i(sys_clk), .miso_i(miso), .miso_oe_i(miso_oe),
    .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // byte write frame
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    host.xfer({2'b10, a, v}, d);
  endtask
  // request frame then a dummy frame that carries the answer
  task automatic rd(input logic [5:0] a, input logic [15:0] exp);
    host.xfer({2'b00, a, 8'h00}, d);
    host.xfer(16'h0000, d);
    chk(d, exp);
  endtask
  task automatic finish_test;
    if (fails == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // watchdog well past the expected length
  initial begin
    repeat (60000) @(posedge sys_clk);
    fails++;
    finish_test();
  end
  // main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rd(6'h36, 16'h0003);
    rd(6'h38, 16'h0102);
    for (int k = 0; k < 3; k++) begin
      wr(6'h39, 8'h01 << k);
      rd(6'h38, {5'h00, 3'h1 << k, 8'h02});
    end
    wr(6'h38, 8'h01);
    wr(6'h36, 8'h08);
    wr(6'h37, 8'hff);
    host.xfer(16'hf605, d);
    wr(6'h04, 8'h55);
    rd(6'h36, 16'h0008);
    rd(6'h38, 16'h0401);
    rd(6'h10, 16'h0000);
    wr(6'h3e, 8'h08);
    chk({15'h0000, prog}, 16'h0001);
    chk(snap_d, 16'h0008);
    chk(snap_r, 16'h0401);
    repeat (60) @(posedge sys_clk);
    chk({15'h0000, prog}, 16'h0000);
    // let the filter settle, then poll until a fresh update is seen
    repeat (11000) @(posedge sys_clk);
    host.xfer(16'h0400, d);
    host.xfer(16'h0400, d);
    d = 16'h0000;
    for (int k = 0; k < 40 && d[15] !== 1'b1; k++) begin
      host.xfer(16'h0400, d);
    end
    chk(d, 16'hfffe);
    host.xfer(16'h0600, d);
    chk(d, 16'h7ffe);
    host.xfer(16'h0200, d);
    chk(d, 16'h0000);
    host.xfer(16'h0a00, d);
    chk(d, 16'hcaaa);
    fault <= 16'h0000;
    host.xfer(16'h0c00, d);
    chk(d, 16'hc7ae);
    host.xfer(16'h0c00, d);
    chk(d, 16'h8e3f);
    host.xfer(16'h0000, d);
    chk(d, 16'h0e3f);
    finish_test();
  end
endmodule
bind gofr_regs gofr_regs_assertions #(.FLASH_CYC(FLASH_CYC)) chk_i (
  .sys_clk_i, .rst_n_i, .spi_sclk_i, .spi_cs_n_i, .spi_miso_o, .spi_miso_oe_o,
  .nvm_prog_o, .nvm_decim_o, .nvm_range_o);
`default_nettype wire
